// ==== acp_pkg.sv ====
package acp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ACP_OFS_SOFT_RESET = 12'h000;
  localparam logic [11:0] ACP_OFS_IF_CFG     = 12'h007;
  localparam logic [11:0] ACP_OFS_PWR        = 12'h008;
  localparam logic [11:0] ACP_OFS_OBUF       = 12'h009;
  localparam logic [11:0] ACP_OFS_FUSE_LOAD  = 12'h013;

  localparam logic [7:0]  ACP_RST_SOFT_RESET = 8'h00;
  localparam logic [7:0]  ACP_RST_IF_CFG     = 8'h00;
  localparam logic [7:0]  ACP_RST_PWR        = 8'h00;
  localparam logic [7:0]  ACP_RST_OBUF       = 8'h00;

  // writable bits; reserved positions are not stored and read as zero
  localparam logic [7:0]  ACP_WMASK_IF_CFG   = 8'hef;
  localparam logic [7:0]  ACP_WMASK_PWR      = 8'h37;
  localparam logic [7:0]  ACP_WMASK_OBUF     = 8'h3f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACP_SRST_BIT    = 0;
  localparam int ACP_FUSE_LD_BIT = 0;
  localparam int ACP_MAP_MSB     = 7;
  localparam int ACP_MAP_LSB     = 5;
  localparam int ACP_OVR_EN_BIT  = 3;
  localparam int ACP_SEL_MSB     = 2;
  localparam int ACP_SEL_LSB     = 0;
  localparam int ACP_CLKBUF_BIT  = 5;
  localparam int ACP_REFAMP_BIT  = 4;
  localparam int ACP_CHA_BIT     = 2;
  localparam int ACP_CHB_BIT     = 1;
  localparam int ACP_GLOBAL_BIT  = 0;
  localparam int ACP_OBUF_MSB    = 5;

  // ----------------------------------------------------------------
  // serial frame: r/w, 3 spare, 12 address, 8 data
  // ----------------------------------------------------------------
  localparam logic [4:0]  ACP_ADDR_BITS  = 5'd16;
  localparam logic [4:0]  ACP_LAST_BIT   = 5'd23;
  localparam int          ACP_RW_POS     = 23;

  // ----------------------------------------------------------------
  // interface codes and lane modes {half, one, two}
  // ----------------------------------------------------------------
  localparam logic [2:0]  ACP_MAP_2L_18_14 = 3'h1;
  localparam logic [2:0]  ACP_MAP_2L_16    = 3'h2;
  localparam logic [2:0]  ACP_MAP_1L       = 3'h3;
  localparam logic [2:0]  ACP_MAP_HALF     = 3'h4;
  localparam logic [2:0]  ACP_SEL_2L       = 3'h3;
  localparam logic [2:0]  ACP_SEL_1L       = 3'h4;
  localparam logic [2:0]  ACP_SEL_HALF     = 3'h5;
  localparam logic [2:0]  ACP_LANES_NONE   = 3'h0;
  localparam logic [2:0]  ACP_LANES_TWO    = 3'h1;
  localparam logic [2:0]  ACP_LANES_ONE    = 3'h2;
  localparam logic [2:0]  ACP_LANES_HALF   = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } acp_state_type;

  function automatic logic [2:0] acp_map_lanes(input logic [2:0] code);
    case (code)
      ACP_MAP_2L_18_14: acp_map_lanes = ACP_LANES_TWO;
      ACP_MAP_2L_16:    acp_map_lanes = ACP_LANES_TWO;
      ACP_MAP_1L:       acp_map_lanes = ACP_LANES_ONE;
      ACP_MAP_HALF:     acp_map_lanes = ACP_LANES_HALF;
      default:          acp_map_lanes = ACP_LANES_NONE;
    endcase
  endfunction : acp_map_lanes

  function automatic logic [2:0] acp_sel_lanes(input logic [2:0] code);
    case (code)
      ACP_SEL_2L:   acp_sel_lanes = ACP_LANES_TWO;
      ACP_SEL_1L:   acp_sel_lanes = ACP_LANES_ONE;
      ACP_SEL_HALF: acp_sel_lanes = ACP_LANES_HALF;
      default:      acp_sel_lanes = ACP_LANES_NONE;
    endcase
  endfunction : acp_sel_lanes

endpackage : acp_pkg

// ==== acp_regs.sv ====
`timescale 1ns/1ps

// Behaviour
// - writing 1 to bit 0 at 0x00 returns all registers to defaults and the bit then clears itself.
// - the lane bit map field in bits 7-5 decodes 001/010 as two-lane, 011 one-lane, 100 half-lane.
// - a new lane bit map only takes effect when the fuse load command at 0x13 bit 0 is issued.
// - the fuse load command discards values written earlier to the power-down (0x08) and output buffer (0x09) registers.
// - after reset the fuse default interface is applied while the fields read back 000.
// - the mode select field overrides the default interface only while the override enable is set.
// - the mode select decodes 011 two-lane, 100 one-lane, 101 half-lane, other codes unused.
// - bit 5 of the power-down register switches off the sampling clock buffer.
// - bit 4 of the power-down register switches off the reference amplifier.
// - bit 2 powers down channel A and bit 1 powers down channel B.
// - bit 0 enters global sleep, with the mask inputs keeping the clock buffer and reference amplifier on; both channels always go off.
// - output_buffer_power_down holds six output driver power-down bits, all reset to 0.
// - each driver bit at 1 disables its driver, with no automatic disable by lane mode.
module acp_regs
  import acp_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // serial register port
  input  wire logic       i_sen_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdio,
  output logic            o_sdio,
  output logic            o_sdio_oe,
  // fuse and mask inputs
  input  wire logic [2:0] i_fuse_lane_map,
  input  wire logic       i_mask_clkbuf,
  input  wire logic       i_mask_refamp,
  // interface selection
  output logic [2:0]      o_lane_mode,
  output logic            o_map_16bit,
  // power controls
  output logic            o_sample_clock_buffer_off,
  output logic            o_reference_amp_off,
  output logic            o_channel_a_off,
  output logic            o_channel_b_off,
  output logic            o_global_sleep_request,
  // output driver controls
  output logic            o_frame_clock_driver_off,
  output logic            o_bit_clock_driver_off,
  output logic            o_chan_a_lane1_driver_off,
  output logic            o_chan_a_lane0_driver_off,
  output logic            o_chan_b_lane1_driver_off,
  output logic            o_chan_b_lane0_driver_off
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  acp_state_type state_reg,      state_next;
  logic [4:0]    cnt_reg,        cnt_next;
  logic [23:0]   shift_reg,      shift_next;
  logic [7:0]    rd_shift_reg,   rd_shift_next;
  logic          sclk_prev_reg,  sclk_prev_next;
  logic          sdio_reg,       sdio_next;
  logic          sdio_oe_reg,    sdio_oe_next;
  logic          srst_reg,       srst_next;
  logic          fld_reg,        fld_next;
  logic          load_pend_reg,  load_pend_next;
  logic [2:0]    active_map_reg, active_map_next;
  logic [7:0]    if_cfg_reg,     if_cfg_next;
  logic [7:0]    pwr_reg,        pwr_next;
  logic [7:0]    obuf_reg,       obuf_next;
  logic [2:0]    lane_reg,       lane_next;
  logic          m16_reg,        m16_next;
  logic [4:0]    pwr_out_reg,    pwr_out_next;
  logic [5:0]    obuf_out_reg,   obuf_out_next;

  logic          rise;
  logic          fall;
  logic          wr_commit;
  logic [11:0]   addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          sleep;

  // ----------------------------------------------------------------
  // serial port and register updates
  // ----------------------------------------------------------------
  always_comb begin
    rise            = i_sclk & ~sclk_prev_reg;
    fall            = ~i_sclk & sclk_prev_reg;
    sclk_prev_next  = i_sclk;
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    shift_next      = shift_reg;
    rd_shift_next   = rd_shift_reg;
    sdio_next       = sdio_reg;
    sdio_oe_next    = sdio_oe_reg;
    srst_next       = 1'b0;
    fld_next        = 1'b0;
    load_pend_next  = load_pend_reg;
    active_map_next = active_map_reg;
    if_cfg_next     = if_cfg_reg;
    pwr_next        = pwr_reg;
    obuf_next       = obuf_reg;
    wr_commit       = 1'b0;
    if (rise) begin
      shift_next = {shift_reg[22:0], i_sdio};
    end
    addr  = shift_next[19:8];
    wdata = shift_next[7:0];
    // read data is latched at the 16th rise, while the address still sits
    // in the low bits of the shifter and not yet in its frame position
    case (shift_next[11:0])
      ACP_OFS_SOFT_RESET: rdata = {7'h00, srst_reg};
      ACP_OFS_IF_CFG:     rdata = if_cfg_reg;
      ACP_OFS_PWR:        rdata = pwr_reg;
      ACP_OFS_OBUF:       rdata = obuf_reg;
      default:            rdata = 8'h00;
    endcase
    if (i_sen_n) begin
      state_next   = ST_IDLE;
      cnt_next     = 5'd0;
      sdio_oe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_ADDR;
          if (rise) begin
            cnt_next = 5'd1;
          end
        end
        ST_ADDR: begin
          if (rise) begin
            cnt_next = cnt_reg + 5'd1;
            if (cnt_next == ACP_ADDR_BITS) begin
              state_next    = ST_DATA;
              rd_shift_next = rdata;
            end
          end
        end
        ST_DATA: begin
          // the r/w bit moves up one place with every data bit shifted in
          if (fall && shift_reg[cnt_reg - 5'd1]) begin
            sdio_next     = rd_shift_reg[7];
            rd_shift_next = {rd_shift_reg[6:0], 1'b0};
            sdio_oe_next  = 1'b1;
          end
          if (rise) begin
            cnt_next = cnt_reg + 5'd1;
            if (cnt_reg == ACP_LAST_BIT) begin
              state_next = ST_DONE;
              wr_commit  = ~shift_next[ACP_RW_POS];
            end
          end
        end
        ST_DONE: begin
          if (fall && sdio_oe_reg) begin
            sdio_oe_next = 1'b0;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    if (wr_commit) begin
      case (addr)
        ACP_OFS_SOFT_RESET: srst_next   = wdata[ACP_SRST_BIT];
        ACP_OFS_IF_CFG:     if_cfg_next = wdata & ACP_WMASK_IF_CFG;
        ACP_OFS_PWR:        pwr_next    = wdata & ACP_WMASK_PWR;
        ACP_OFS_OBUF:       obuf_next   = wdata & ACP_WMASK_OBUF;
        ACP_OFS_FUSE_LOAD:  fld_next    = wdata[ACP_FUSE_LD_BIT];
        default:            fld_next    = 1'b0;
      endcase
    end
    // the fuse interface is picked up one cycle after reset, since an
    // asynchronous reset may not load a port value
    if (load_pend_reg) begin
      active_map_next = i_fuse_lane_map;
      load_pend_next  = 1'b0;
    end
    if (fld_reg) begin
      // mapping written before the load is honoured, and in the same cycle
      // earlier writes to the power registers are thrown away
      if (if_cfg_reg[ACP_MAP_MSB:ACP_MAP_LSB] != 3'h0) begin
        active_map_next = if_cfg_reg[ACP_MAP_MSB:ACP_MAP_LSB];
      end else begin
        active_map_next = i_fuse_lane_map;
      end
      pwr_next  = ACP_RST_PWR;
      obuf_next = ACP_RST_OBUF;
    end
    if (srst_reg) begin
      if_cfg_next    = ACP_RST_IF_CFG;
      pwr_next       = ACP_RST_PWR;
      obuf_next      = ACP_RST_OBUF;
      fld_next       = 1'b0;
      load_pend_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (if_cfg_reg[ACP_OVR_EN_BIT] &&
        acp_sel_lanes(if_cfg_reg[ACP_SEL_MSB:ACP_SEL_LSB]) !=
        ACP_LANES_NONE) begin
      lane_next = acp_sel_lanes(if_cfg_reg[ACP_SEL_MSB:ACP_SEL_LSB]);
    end else begin
      lane_next = acp_map_lanes(active_map_reg);
    end
    m16_next = (active_map_reg == ACP_MAP_2L_16);
    sleep    = pwr_reg[ACP_GLOBAL_BIT];
    pwr_out_next = {
      pwr_reg[ACP_CLKBUF_BIT] | (sleep & ~i_mask_clkbuf),
      pwr_reg[ACP_REFAMP_BIT] | (sleep & ~i_mask_refamp),
      pwr_reg[ACP_CHA_BIT] | sleep,
      pwr_reg[ACP_CHB_BIT] | sleep,
      sleep
    };
    // lane drivers follow their bits only, never the lane mode
    obuf_out_next = obuf_reg[ACP_OBUF_MSB:0];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 5'd0;
      shift_reg      <= 24'h000000;
      rd_shift_reg   <= 8'h00;
      sclk_prev_reg  <= 1'b0;
      sdio_reg       <= 1'b0;
      sdio_oe_reg    <= 1'b0;
      srst_reg       <= ACP_RST_SOFT_RESET[ACP_SRST_BIT];
      fld_reg        <= 1'b0;
      load_pend_reg  <= 1'b1;
      active_map_reg <= 3'h0;
      if_cfg_reg     <= ACP_RST_IF_CFG;
      pwr_reg        <= ACP_RST_PWR;
      obuf_reg       <= ACP_RST_OBUF;
      lane_reg       <= ACP_LANES_NONE;
      m16_reg        <= 1'b0;
      pwr_out_reg    <= 5'h00;
      obuf_out_reg   <= 6'h00;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      shift_reg      <= shift_next;
      rd_shift_reg   <= rd_shift_next;
      sclk_prev_reg  <= sclk_prev_next;
      sdio_reg       <= sdio_next;
      sdio_oe_reg    <= sdio_oe_next;
      srst_reg       <= srst_next;
      fld_reg        <= fld_next;
      load_pend_reg  <= load_pend_next;
      active_map_reg <= active_map_next;
      if_cfg_reg     <= if_cfg_next;
      pwr_reg        <= pwr_next;
      obuf_reg       <= obuf_next;
      lane_reg       <= lane_next;
      m16_reg        <= m16_next;
      pwr_out_reg    <= pwr_out_next;
      obuf_out_reg   <= obuf_out_next;
    end
  end

  assign o_sdio                    = sdio_reg;
  assign o_sdio_oe                 = sdio_oe_reg;
  assign o_lane_mode               = lane_reg;
  assign o_map_16bit               = m16_reg;
  assign o_sample_clock_buffer_off = pwr_out_reg[4];
  assign o_reference_amp_off       = pwr_out_reg[3];
  assign o_channel_a_off           = pwr_out_reg[2];
  assign o_channel_b_off           = pwr_out_reg[1];
  assign o_global_sleep_request    = pwr_out_reg[0];
  assign o_frame_clock_driver_off  = obuf_out_reg[5];
  assign o_bit_clock_driver_off    = obuf_out_reg[4];
  assign o_chan_a_lane1_driver_off = obuf_out_reg[3];
  assign o_chan_a_lane0_driver_off = obuf_out_reg[2];
  assign o_chan_b_lane1_driver_off = obuf_out_reg[1];
  assign o_chan_b_lane0_driver_off = obuf_out_reg[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_soft_reset_clears: assert property (
    srst_reg |=> (!srst_reg && if_cfg_reg == 8'h00 && pwr_reg == 8'h00
                  && obuf_reg == 8'h00 && load_pend_reg))
    else $error("soft reset did not restore defaults");

  a_map_decode: assert property (
    !if_cfg_reg[ACP_OVR_EN_BIT] && active_map_reg == ACP_MAP_HALF
    |=> o_lane_mode == ACP_LANES_HALF)
    else $error("lane map decode wrong");

  a_map_waits_load: assert property (
    !fld_reg && !load_pend_reg |=> $stable(active_map_reg))
    else $error("lane map changed without fuse load");

  a_fuse_discards: assert property (
    fld_reg && !srst_reg |=> pwr_reg == 8'h00 ##0 obuf_reg == 8'h00)
    else $error("fuse load kept earlier writes");

  a_fuse_default: assert property (
    load_pend_reg && !fld_reg |=> active_map_reg == $past(i_fuse_lane_map)
    && if_cfg_reg == $past(if_cfg_reg))
    else $error("fuse default not applied");

  a_override_sel: assert property (
    if_cfg_reg[ACP_OVR_EN_BIT] && if_cfg_reg[2:0] == ACP_SEL_1L
    |=> o_lane_mode == ACP_LANES_ONE)
    else $error("override select ignored");

  a_clkbuf_off: assert property (
    ##1 o_sample_clock_buffer_off == $past(pwr_reg[ACP_CLKBUF_BIT]
    | (pwr_reg[ACP_GLOBAL_BIT] & ~i_mask_clkbuf)))
    else $error("clock buffer control wrong");

  a_refamp_off: assert property (
    $rose(pwr_reg[ACP_REFAMP_BIT]) |=> o_reference_amp_off)
    else $error("reference amp not switched off");

  a_channel_off: assert property (
    pwr_reg[ACP_CHB_BIT] && !pwr_reg[ACP_CHA_BIT] && !pwr_reg[ACP_GLOBAL_BIT]
    |=> o_channel_b_off && !o_channel_a_off)
    else $error("channel power control wrong");

  a_global_sleep: assert property (
    pwr_reg[ACP_GLOBAL_BIT] && i_mask_refamp
    |=> o_global_sleep_request && o_channel_a_off && o_channel_b_off)
    else $error("global sleep not applied");

  a_driver_bits: assert property (
    ##1 {o_frame_clock_driver_off, o_bit_clock_driver_off,
         o_chan_a_lane1_driver_off, o_chan_a_lane0_driver_off,
         o_chan_b_lane1_driver_off, o_chan_b_lane0_driver_off}
        == $past(obuf_reg[5:0]))
    else $error("driver power-down bits wrong");

endmodule : acp_regs

// ==== acp_host_model.sv ====
`timescale 1ns/1ps

module acp_host_model
  import acp_pkg::*;
(
  // clock
  input  wire logic i_clk,
  // serial register port
  output logic      o_sen_n,
  output logic      o_sclk,
  output logic      o_sdio,
  input  wire logic i_sdio,
  input  wire logic i_sdio_oe
);
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // the device edge-detects sclk on i_clk, so each level is kept long
  // enough for the detector plus the one-cycle launch of read data
  localparam int SCLK_HALF = 4;

  initial begin
    o_sen_n = 1'b1;
    o_sclk  = 1'b0;
    o_sdio  = 1'b0;
  end

  function automatic logic [7:0] wmask(input logic [11:0] addr);
    case (addr)
      ACP_OFS_IF_CFG: wmask = ACP_WMASK_IF_CFG;
      ACP_OFS_PWR:    wmask = ACP_WMASK_PWR;
      ACP_OFS_OBUF:   wmask = ACP_WMASK_OBUF;
      default:        wmask = 8'h01;
    endcase
  endfunction : wmask

  task automatic half_wait();
    repeat (SCLK_HALF) @(posedge i_clk);
  endtask : half_wait

  // ----------------------------------------------------------------
  // one 24-bit frame, msb first
  // ----------------------------------------------------------------
  task automatic xfer(input  logic        rd,
                      input  logic [11:0] addr,
                      input  logic [7:0]  wdata,
                      output logic [7:0]  rdata,
                      output logic        oe_ok);
    logic [23:0] frame;
    frame = {rd, 3'h0, addr, wdata & wmask(addr)};
    rdata = 8'h00;
    oe_ok = 1'b1;
    @(posedge i_clk);
    o_sen_n <= 1'b0;
    for (int b = 23; b >= 0; b--) begin
      // during read data the host has released the line: it toggles
      o_sdio <= (rd && b < 8) ? ~o_sdio : frame[b];
      o_sclk <= 1'b0;
      half_wait();
      o_sclk <= 1'b1;
      if (rd && b < 8) begin
        rdata[b] = i_sdio;
        oe_ok    = oe_ok & i_sdio_oe;
      end
      half_wait();
    end
    o_sclk <= 1'b0;
    half_wait();
    o_sen_n <= 1'b1;
    o_sdio  <= ~o_sdio;
    half_wait();
  endtask : xfer

endmodule : acp_host_model

// ==== tb_acp_regs.sv ====
`timescale 1ns/1ps

module tb_acp_regs
  import acp_pkg::*;
;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       sen_n, sclk, sdio_h;
  logic       o_sdio, o_sdio_oe;
  logic [2:0] i_fuse_lane_map = ACP_MAP_2L_16;
  logic       i_mask_clkbuf = 1'b0;
  logic       i_mask_refamp = 1'b0;
  logic [2:0] o_lane_mode;
  logic       o_map_16bit;
  logic [4:0] pwr;
  logic [5:0] drv;
  int         miscompares = 0;
  int         checks = 0;

  always #4 i_clk = ~i_clk;

  acp_regs acp_regs_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_sen_n(sen_n), .i_sclk(sclk),
    .i_sdio(sdio_h), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe),
    .i_fuse_lane_map(i_fuse_lane_map), .i_mask_clkbuf(i_mask_clkbuf),
    .i_mask_refamp(i_mask_refamp), .o_lane_mode(o_lane_mode),
    .o_map_16bit(o_map_16bit),
    .o_sample_clock_buffer_off(pwr[4]), .o_reference_amp_off(pwr[3]),
    .o_channel_a_off(pwr[2]), .o_channel_b_off(pwr[1]),
    .o_global_sleep_request(pwr[0]),
    .o_frame_clock_driver_off(drv[5]), .o_bit_clock_driver_off(drv[4]),
    .o_chan_a_lane1_driver_off(drv[3]), .o_chan_a_lane0_driver_off(drv[2]),
    .o_chan_b_lane1_driver_off(drv[1]), .o_chan_b_lane0_driver_off(drv[0])
  );

  acp_host_model acp_host_model_i (
    .i_clk(i_clk), .o_sen_n(sen_n), .o_sclk(sclk), .o_sdio(sdio_h),
    .i_sdio(o_sdio), .i_sdio_oe(o_sdio_oe)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ok;
    acp_host_model_i.xfer(1'b0, a, d, r, ok);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       ok;
    acp_host_model_i.xfer(1'b1, a, 8'h00, r, ok);
    check("read data", r, exp);
    check("sdio enable", {7'h0, ok}, 8'h01);
  endtask : rd_chk

  function automatic logic [7:0] lane(input logic m16, input logic [2:0] l);
    lane = {4'h0, m16, l};
  endfunction : lane

  // expected power outputs from register value and masks
  function automatic logic [7:0] pwr_exp(input logic [7:0] v,
                                         input logic [1:0] m);
    pwr_exp = {3'h0, v[5] | (v[0] & ~m[0]), v[4] | (v[0] & ~m[1]),
               v[2] | v[0], v[1] | v[0], v[0]};
  endfunction : pwr_exp

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] e;
    logic [7:0] pv [5];
    pv = '{8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    check("lane", {4'h0, o_map_16bit, o_lane_mode}, lane(1'b1, ACP_LANES_TWO));
    rd_chk(ACP_OFS_IF_CFG, 8'h00);
    rd_chk(ACP_OFS_SOFT_RESET, ACP_RST_SOFT_RESET);
    rd_chk(ACP_OFS_PWR, ACP_RST_PWR);
    rd_chk(ACP_OFS_OBUF, ACP_RST_OBUF);
    check("drivers", {2'h0, drv}, 8'h00);
    $display("test reset done");

    wr(ACP_OFS_IF_CFG, 8'h60);
    check("lane", {4'h0, o_map_16bit, o_lane_mode}, lane(1'b1, ACP_LANES_TWO));
    for (int c = 1; c < 8; c++) begin
      wr(ACP_OFS_IF_CFG, {c[2:0], 5'h00});
      wr(ACP_OFS_FUSE_LOAD, 8'h01);
      case (c)
        1:       e = lane(1'b0, ACP_LANES_TWO);
        2:       e = lane(1'b1, ACP_LANES_TWO);
        3:       e = lane(1'b0, ACP_LANES_ONE);
        4:       e = lane(1'b0, ACP_LANES_HALF);
        default: e = lane(1'b0, ACP_LANES_NONE);
      endcase
      check("lane", {4'h0, o_map_16bit, o_lane_mode}, e);
    end
    $display("test lane map done");

    wr(ACP_OFS_IF_CFG, 8'h60);
    wr(ACP_OFS_PWR, 8'h20);
    wr(ACP_OFS_OBUF, 8'h3f);
    wr(ACP_OFS_FUSE_LOAD, 8'h01);
    rd_chk(ACP_OFS_PWR, 8'h00);
    rd_chk(ACP_OFS_OBUF, 8'h00);
    check("drivers", {2'h0, drv}, 8'h00);
    rd_chk(ACP_OFS_IF_CFG, 8'h60);
    check("lane", {4'h0, o_map_16bit, o_lane_mode}, lane(1'b0, ACP_LANES_ONE));
    $display("test fuse load done");

    for (int s = 0; s < 8; s++) begin
      wr(ACP_OFS_IF_CFG, {3'h3, 2'b01, s[2:0]});
      case (s)
        3:       e = lane(1'b0, ACP_LANES_TWO);
        4:       e = lane(1'b0, ACP_LANES_ONE);
        5:       e = lane(1'b0, ACP_LANES_HALF);
        default: e = lane(1'b0, ACP_LANES_ONE);
      endcase
      check("lane", {4'h0, o_map_16bit, o_lane_mode}, e);
    end
    wr(ACP_OFS_IF_CFG, 8'h65);
    check("lane", {4'h0, o_map_16bit, o_lane_mode}, lane(1'b0, ACP_LANES_ONE));
    check("drivers", {2'h0, drv}, 8'h00);
    $display("test mode select done");

    for (int i = 0; i < 6; i++) begin
      wr(ACP_OFS_OBUF, 8'h01 << i);
      check("drivers", {2'h0, drv}, 8'h01 << i);
      rd_chk(ACP_OFS_OBUF, 8'h01 << i);
    end
    $display("test driver bits done");

    for (int m = 0; m < 4; m++) begin
      @(posedge i_clk);
      i_mask_clkbuf <= m[0];
      i_mask_refamp <= m[1];
      for (int k = 0; k < 5; k++) begin
        wr(ACP_OFS_PWR, pv[k]);
        check("power", {3'h0, pwr}, pwr_exp(pv[k], m[1:0]));
      end
    end
    wr(ACP_OFS_PWR, 8'h37);
    check("power", {3'h0, pwr}, 8'h1f);
    rd_chk(ACP_OFS_PWR, 8'h37);
    $display("test power done");

    wr(ACP_OFS_OBUF, 8'h3f);
    wr(ACP_OFS_IF_CFG, 8'h8c);
    @(posedge i_clk);
    i_fuse_lane_map <= ACP_MAP_HALF;
    wr(ACP_OFS_SOFT_RESET, 8'h01);
    rd_chk(ACP_OFS_SOFT_RESET, 8'h00);
    rd_chk(ACP_OFS_IF_CFG, 8'h00);
    rd_chk(ACP_OFS_PWR, 8'h00);
    rd_chk(ACP_OFS_OBUF, 8'h00);
    check("power", {3'h0, pwr}, 8'h00);
    check("drivers", {2'h0, drv}, 8'h00);
    check("lane", {4'h0, o_map_16bit, o_lane_mode}, lane(1'b0, ACP_LANES_HALF));
    $display("test soft reset done");
    complete_run();
  end

  // bound on the whole run
  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end

endmodule : tb_acp_regs
